// ===== tmr16_regs.svh
// Purpose: register indices, byte addresses, field positions, resets
// Assumes: index times four gives the AXI4-Lite byte address
// Notes: one aligned 32-bit word per register, data in the low bits
`ifndef TMR16_REGS_SVH
`define TMR16_REGS_SVH

// ----------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------
`define FLAG_REG_IDX 12'h00c
`define ENABLE_REG_IDX 12'h08c
`define COUNT_LOW_IDX 12'h00e
`define COUNT_HIGH_IDX 12'h00f
`define CONTROL_IDX 12'h010
`define ADDR_OF(idx) ({(idx), 2'b00})

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define CTL_RUN 0
`define CTL_CLK_SEL 1
`define CTL_SYNC_N 2
`define CTL_OSC_EN 3
`define CTL_DIV_LO 4
`define CTL_DIV_HI 5
`define CTL_WIDTH 6
`define CTL_RESET 6'h00
`define OVF_BIT 0
`define IRQ_EN_BIT 0

// ----------------------------------------------------------------
// timing and answers
// ----------------------------------------------------------------
`define INST_DIV 4
`define PIN_SYNC_STAGES 3
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ===== tmr16_pkg.sv
// Purpose: shared types of the 16-bit timer/counter
// Assumes: nothing beyond the register header
// Notes: types only, constants live in the header
`default_nettype none

package tmr16_pkg;
    typedef logic [15:0] count_t;
    typedef logic [1:0] axi_resp_t;
    typedef logic [13:0] axi_addr_t;
    typedef enum {
        SEL_NONE,
        SEL_FLAG,
        SEL_ENABLE,
        SEL_LOW,
        SEL_HIGH,
        SEL_CONTROL
    } reg_sel_t;
endpackage

`default_nettype wire

// ===== tmr16_counter.sv
// Purpose: 16-bit timer/counter with prescaler behind AXI4-Lite
// Assumes: CLOCK is the core oscillator, SLEEP comes from CLOCK logic
// Notes: the count pair has no reset; it holds x until written
//
// Functional notes
// - 16-bit count, byte access, wraps up
// - wrap latches flag; enable gates interrupt
// - timer mode counts core clock over four
// - counter mode counts external rising edges
// - run bit clear holds the count
// - divide field picks 1:1 to 1:8
// - count byte write clears prescaler
// - oscillator enable starts low-power oscillator
// - oscillator enable forces both pins input
// - oscillator enable picks oscillator input pin
// - sync bit clear synchronises external clock
// - synchronise after prescaler, prescaler counts input
// - timer mode ignores sync bit
// - synced counter stalls in sleep, prescaler runs
// - unsynced counter runs in sleep, wakes
// - async counter is no capture timebase
// - count reads always return valid value
// - compare trigger resets count to zero
// - trigger reset never sets overflow flag
// - trigger reset ignored in async counter mode
// - count write beats coincident trigger
// - power-on reset clears control; others keep
// - count untouched by any device reset
`include "tmr16_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module tmr16_counter #(
    parameter int PRESC_W = 3
) (
    // clock and resets
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic OTHER_RST,
    // device state and trigger sources
    input wire logic SLEEP,
    input wire logic CCU_A_TRIG,
    input wire logic CCU_B_TRIG,
    // pins
    input wire logic OSC_IN_PIN,
    input wire logic EXT_CLOCK_PIN,
    input wire logic [1:0] PORT_C_DIRECTION,
    output logic [1:0] PORT_C_DIR_EFF,
    output logic OSC_RUN,
    // status
    output logic OVF_IRQ,
    output logic TIMEBASE_OK,
    // axi4-lite write address and data
    input wire logic AWVALID,
    output logic AWREADY,
    input wire tmr16_pkg::axi_addr_t AWADDR,
    input wire logic [2:0] AWPROT,
    input wire logic WVALID,
    output logic WREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    // axi4-lite write response
    output logic BVALID,
    input wire logic BREADY,
    output tmr16_pkg::axi_resp_t BRESP,
    // axi4-lite read
    input wire logic ARVALID,
    output logic ARREADY,
    input wire tmr16_pkg::axi_addr_t ARADDR,
    input wire logic [2:0] ARPROT,
    output logic RVALID,
    input wire logic RREADY,
    output logic [31:0] RDATA,
    output tmr16_pkg::axi_resp_t RRESP
);
    import tmr16_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic reg_sel_t decode(input axi_addr_t a);
        reg_sel_t s;
        s = SEL_NONE;
        case (a)
            `ADDR_OF(`FLAG_REG_IDX): s = SEL_FLAG;
            `ADDR_OF(`ENABLE_REG_IDX): s = SEL_ENABLE;
            `ADDR_OF(`COUNT_LOW_IDX): s = SEL_LOW;
            `ADDR_OF(`COUNT_HIGH_IDX): s = SEL_HIGH;
            `ADDR_OF(`CONTROL_IDX): s = SEL_CONTROL;
            default: s = SEL_NONE;
        endcase
        return s;
    endfunction

    function automatic logic [PRESC_W-1:0] div_mask(input logic [1:0] f);
        logic [PRESC_W-1:0] m;
        m = '0;
        case (f)
            2'b00: m = PRESC_W'(3'h0);
            2'b01: m = PRESC_W'(3'h1);
            2'b10: m = PRESC_W'(3'h3);
            default: m = PRESC_W'(3'h7);
        endcase
        return m;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [`CTL_WIDTH-1:0] ctrl_q;
    logic flag_q, irq_en_q;
    count_t count_q;
    logic [PRESC_W-1:0] presc_q;
    logic [1:0] inst_q;
    logic [`PIN_SYNC_STAGES-1:0] osc_s_q, ext_s_q;
    logic pin_lvl_q;
    logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
    axi_addr_t awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    axi_resp_t bresp_q, rresp_q;

    logic run, clk_sel, sync_n, osc_en, async_mode;
    logic sel2, sel3, pin_rise, inst_tick, src_tick, pre_out, inc;
    logic wr_fire, lane0, trig, wr_low, wr_high, wr_count, ovf_set;
    reg_sel_t wsel, rsel;

    assign run = ctrl_q[`CTL_RUN];
    assign clk_sel = ctrl_q[`CTL_CLK_SEL];
    assign sync_n = ctrl_q[`CTL_SYNC_N];
    assign osc_en = ctrl_q[`CTL_OSC_EN];
    // sync bit only matters with the external source
    assign async_mode = clk_sel && sync_n;

    // ----------------------------------------------------------------
    // pin inputs
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            osc_s_q <= '0;
            ext_s_q <= '0;
        end else begin
            osc_s_q <= {osc_s_q[`PIN_SYNC_STAGES-2:0], OSC_IN_PIN};
            ext_s_q <= {ext_s_q[`PIN_SYNC_STAGES-2:0], EXT_CLOCK_PIN};
        end
    end

    // oscillator enable chooses which pin feeds the counter
    assign sel2 = osc_en ? osc_s_q[1] : ext_s_q[1];
    assign sel3 = osc_en ? osc_s_q[2] : ext_s_q[2];
    assign pin_rise = (sel2 == sel3) && sel2 && !pin_lvl_q;

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            pin_lvl_q <= 1'b0;
        end else if (sel2 == sel3) begin
            pin_lvl_q <= sel2;
        end
    end

    assign OSC_RUN = osc_en;
    // pins stay inputs while the oscillator owns them
    assign PORT_C_DIR_EFF = osc_en ? 2'b11 : PORT_C_DIRECTION;

    // ----------------------------------------------------------------
    // clock source and prescaler
    // ----------------------------------------------------------------
    // core clock stops in sleep, so the instruction tick stops too
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            inst_q <= 2'h0;
        end else if (!SLEEP) begin
            inst_q <= inst_q + 2'h1;
        end
    end

    assign inst_tick = !SLEEP && (inst_q == 2'(`INST_DIV - 1));
    assign src_tick = run && (clk_sel ? pin_rise : inst_tick);
    assign pre_out = src_tick
        && ((presc_q & div_mask(ctrl_q[`CTL_DIV_HI:`CTL_DIV_LO]))
            == div_mask(ctrl_q[`CTL_DIV_HI:`CTL_DIV_LO]));

    // prescaler sits ahead of the sleep gate and keeps counting
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            presc_q <= '0;
        end else if (wr_count) begin
            presc_q <= '0;
        end else if (pre_out) begin
            presc_q <= '0;
        end else if (src_tick) begin
            presc_q <= presc_q + PRESC_W'(1);
        end
    end

    // synced counter mode loses its sync stage in sleep
    assign inc = pre_out && !(clk_sel && !sync_n && SLEEP);

    // ----------------------------------------------------------------
    // count pair
    // ----------------------------------------------------------------
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign wsel = decode(awaddr_q);
    assign lane0 = wstrb_q[0];
    assign wr_low = wr_fire && lane0 && (wsel == SEL_LOW);
    assign wr_high = wr_fire && lane0 && (wsel == SEL_HIGH);
    assign wr_count = wr_low || wr_high;
    // trigger is not honoured against an unsynced clock
    assign trig = (CCU_A_TRIG || CCU_B_TRIG) && !async_mode;
    assign ovf_set = inc && (count_q == 16'hffff)
        && !wr_count && !trig;

    // no reset branch: device resets leave the count alone
    always_ff @(posedge CLOCK) begin
        if (wr_count) begin
            if (wr_low) begin
                count_q[7:0] <= wdata_q[7:0];
            end
            if (wr_high) begin
                count_q[15:8] <= wdata_q[7:0];
            end
        end else if (trig) begin
            count_q <= 16'h0000;
        end else if (inc) begin
            count_q <= count_q + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // control, flag and enable
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            ctrl_q <= `CTL_RESET;
        end else if (wr_fire && lane0 && wsel == SEL_CONTROL) begin
            ctrl_q <= wdata_q[`CTL_WIDTH-1:0];
        end
    end

    // a wrap in the clearing cycle still leaves the flag set
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            flag_q <= 1'b0;
            irq_en_q <= 1'b0;
        end else if (OTHER_RST) begin
            flag_q <= 1'b0;
            irq_en_q <= 1'b0;
        end else begin
            if (ovf_set) begin
                flag_q <= 1'b1;
            end else if (wr_fire && lane0 && wsel == SEL_FLAG) begin
                flag_q <= wdata_q[`OVF_BIT];
            end
            if (wr_fire && lane0 && wsel == SEL_ENABLE) begin
                irq_en_q <= wdata_q[`IRQ_EN_BIT];
            end
        end
    end

    // unsynced mode keeps this alive in sleep for wake-up
    assign OVF_IRQ = flag_q && irq_en_q;
    assign TIMEBASE_OK = !async_mode;

    // ----------------------------------------------------------------
    // axi4-lite write side
    // ----------------------------------------------------------------
    assign AWREADY = !aw_have_q && !bvalid_q;
    assign WREADY = !w_have_q && !bvalid_q;
    assign BVALID = bvalid_q;
    assign BRESP = bresp_q;

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_have_q <= 1'b1;
                awaddr_q <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_have_q <= 1'b1;
                wdata_q <= WDATA;
                wstrb_q <= WSTRB;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (wsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
            end else if (bvalid_q && BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read side
    // ----------------------------------------------------------------
    assign ARREADY = !rvalid_q;
    assign RVALID = rvalid_q;
    assign RDATA = rdata_q;
    assign RRESP = rresp_q;
    assign rsel = decode(ARADDR);

    // count lives in this clock, so a byte read is never torn
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            rvalid_q <= 1'b1;
            rresp_q <= `RESP_OKAY;
            case (rsel)
                SEL_FLAG: rdata_q <= {31'h0, flag_q};
                SEL_ENABLE: rdata_q <= {31'h0, irq_en_q};
                SEL_LOW: rdata_q <= {24'h0, count_q[7:0]};
                SEL_HIGH: rdata_q <= {24'h0, count_q[15:8]};
                SEL_CONTROL: rdata_q <= {26'h0, ctrl_q};
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= `RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_wrap_sets_flag: assert property (@(posedge CLOCK) disable iff (RST)
        inc && count_q == 16'hffff && !wr_count && !trig && !OTHER_RST
        |=> flag_q && count_q == 16'h0000)
        else $error("wrap did not set the overflow flag");

    chk_trig_zeroes: assert property (@(posedge CLOCK) disable iff (RST)
        trig && !wr_count |=> count_q == 16'h0000)
        else $error("trigger did not clear the count");

    chk_trig_no_flag: assert property (@(posedge CLOCK) disable iff (RST)
        trig && !flag_q |=> !flag_q)
        else $error("trigger reset set the overflow flag");

    chk_write_beats_trig: assert property (@(posedge CLOCK) disable iff (RST)
        wr_low && trig |=> count_q[7:0] == $past(wdata_q[7:0]))
        else $error("trigger overrode a count write");

    chk_stopped_holds: assert property (@(posedge CLOCK) disable iff (RST)
        !run && !wr_count && !trig [*2] |-> $stable(count_q))
        else $error("count moved while stopped");

    chk_sleep_sync_hold: assert property (@(posedge CLOCK) disable iff (RST)
        clk_sel && !sync_n && SLEEP && !wr_count && !trig
        |=> count_q == $past(count_q))
        else $error("synced counter advanced in sleep");

    chk_presc_cleared: assert property (@(posedge CLOCK) disable iff (RST)
        wr_count |=> presc_q == '0)
        else $error("prescaler not cleared by count write");

    chk_timer_rate: assert property (@(posedge CLOCK) disable iff (RST)
        inc && !clk_sel |-> !$past(inc, 1) && !$past(inc, 2)
            && !$past(inc, 3))
        else $error("timer mode advanced faster than core clock over four");

    chk_irq_gate: assert property (@(posedge CLOCK) disable iff (RST)
        ovf_set && irq_en_q && !OTHER_RST |=> OVF_IRQ)
        else $error("enabled overflow raised no interrupt");

    chk_osc_pins_in: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(osc_en) |-> PORT_C_DIR_EFF == 2'b11)
        else $error("oscillator pins not forced to input");

endmodule

`default_nettype wire

// ===== tmr16_clk_src.sv
// Purpose: far-side clock source or crystal driving the timer pins
// Assumes: both pins rest low between bursts
// Notes: edges land on core clock edges so runs repeat exactly
`timescale 1ns/10ps
`default_nettype none

module tmr16_clk_src (
    // pacing clock
    input wire logic clk,
    // pin levels
    output logic ext_pin,
    output logic osc_pin
);
    initial begin
        ext_pin = 1'b0;
        osc_pin = 1'b0;
    end

    // ----------------------------------------
    // burst of n rising edges, h cycles a level
    // ----------------------------------------
    // only the chosen pin moves, the other stays low
    task automatic burst(input int n, input int h, input bit osc);
        for (int i = 0; i < n; i++) begin
            repeat (h) @(posedge clk);
            osc_pin <= osc;
            ext_pin <= !osc;
            repeat (h) @(posedge clk);
            osc_pin <= 1'b0;
            ext_pin <= 1'b0;
        end
    endtask
endmodule

`default_nettype wire

// ===== sixteen_bit_timer_counter_tb_top.sv
// Purpose: self-checking bench for the 16-bit timer/counter
// Assumes: 10 MHz core clock, bench is the AXI4-Lite master
// Notes: count model kept in integers, compared at every rcnt read
`include "tmr16_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module sixteen_bit_timer_counter_tb_top;
    import tmr16_pkg::*;
    localparam axi_addr_t A_FL = `ADDR_OF(`FLAG_REG_IDX);
    localparam axi_addr_t A_EN = `ADDR_OF(`ENABLE_REG_IDX);
    localparam axi_addr_t A_LO = `ADDR_OF(`COUNT_LOW_IDX);
    localparam axi_addr_t A_HI = `ADDR_OF(`COUNT_HIGH_IDX);
    localparam axi_addr_t A_CT = `ADDR_OF(`CONTROL_IDX);
    logic clk, rst, orst, sleep, trig_a, trig_b, osc_run, irq, tb_ok;
    logic ext_pin, osc_pin, awvalid, awready, wvalid, wready;
    logic bvalid, bready, arvalid, arready, rvalid, rready;
    logic [1:0] dir, dir_eff;
    logic [3:0] wstrb;
    logic [31:0] wdata, rdata, rv;
    logic [7:0] mctl;
    axi_addr_t awaddr, araddr;
    axi_resp_t bresp, rresp, resp;
    int num_errors = 0;
    int total_checks = 0;
    int mcnt, mflag, men, mpre, cseen, t;

    tmr16_counter u_dut (.CLOCK(clk), .RST(rst), .OTHER_RST(orst),
        .SLEEP(sleep), .CCU_A_TRIG(trig_a), .CCU_B_TRIG(trig_b),
        .OSC_IN_PIN(osc_pin), .EXT_CLOCK_PIN(ext_pin),
        .PORT_C_DIRECTION(dir), .PORT_C_DIR_EFF(dir_eff),
        .OSC_RUN(osc_run), .OVF_IRQ(irq), .TIMEBASE_OK(tb_ok),
        .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr),
        .AWPROT(3'h0), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata),
        .WSTRB(wstrb), .BVALID(bvalid), .BREADY(bready), .BRESP(bresp),
        .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr),
        .ARPROT(3'h0), .RVALID(rvalid), .RREADY(rready), .RDATA(rdata),
        .RRESP(rresp));
    tmr16_clk_src u_src (.clk(clk), .ext_pin(ext_pin), .osc_pin(osc_pin));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ------------------------------
    // checking and reporting
    // ------------------------------
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %0s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------
    // bus master, answers sampled at rising edges
    // ------------------------------
    task automatic wr(input axi_addr_t a, input logic [31:0] d,
                      input logic [3:0] s, input bit trg);
        bit b;
        b = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        trig_a <= trg;
        for (int n = 0; n < 40 && !b; n++) begin
            @(posedge clk);
            // trigger stays up through the edge the write lands on
            if (!awvalid && !wvalid) trig_a <= 1'b0;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                bready <= 1'b0;
                b = 1;
            end
        end
        chk("write answer", 32'(b), 32'h1);
    endtask

    task automatic rd(input axi_addr_t a, output logic [31:0] d);
        bit r;
        r = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 40 && !r; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                resp = rresp;
                rready <= 1'b0;
                r = 1;
            end
        end
        chk("read answer", 32'(r), 32'h1);
    endtask

    task automatic rchk(input axi_addr_t a, input logic [31:0] e,
                        input string nm);
        rd(a, rv);
        chk(nm, rv, e);
        chk("read resp", 32'(resp), 32'h0);
    endtask

    // ------------------------------
    // model of count and prescaler
    // ------------------------------
    task automatic wctl(input logic [7:0] v);
        wr(A_CT, 32'(v), 4'h1, 0);
        mctl = v & 8'h3f;
    endtask

    task automatic wcnt(input logic [15:0] v);
        wr(A_LO, 32'(v[7:0]), 4'h1, 0);
        wr(A_HI, 32'(v[15:8]), 4'h1, 0);
        mcnt = v;
        mpre = 0;
    endtask

    task automatic rgot();
        logic [31:0] lo;
        rd(A_LO, lo);
        rd(A_HI, rv);
        cseen = {rv[7:0], lo[7:0]};
    endtask

    task automatic rcnt(input string nm);
        rgot();
        chk(nm, 32'(cseen), 32'(mcnt));
    endtask

    task automatic pulse(input int n, input bit osc);
        u_src.burst(n, 3 + $urandom % 4, osc);
        repeat (6) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            if (mctl[0] && mctl[1] && osc == mctl[3]) begin
                mpre++;
                if (mpre == (1 << mctl[5:4])) begin
                    mpre = 0;
                    // synced edges are lost in sleep
                    if (!sleep || mctl[2]) begin
                        mcnt = (mcnt + 1) % 65536;
                        mflag = mflag | (mcnt == 0);
                    end
                end
            end
        end
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        final_report();
    end

    initial begin
        {rst, orst, sleep, trig_a, trig_b, dir} = 7'h40;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = '0;
        {mctl, mflag, men, mpre, mcnt} = '0;
        void'($urandom(32'h3e784da6));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rchk(A_CT, 32'h0, "ctl reset");
        rchk(A_FL, 32'h0, "flag reset");
        rchk(A_EN, 32'h0, "enable reset");
        rd(14'h0100, rv);
        chk("unmapped", {rv[29:0], resp}, 32'h2);
        wctl(8'hff);
        rchk(A_CT, 32'h3f, "ctl bits");
        wr(A_CT, 32'h0, 4'h0, 0);
        rchk(A_CT, 32'h3f, "strobe off");
        dir <= 2'($urandom);
        @(negedge clk);
        chk("osc on", 32'({osc_run, dir_eff}), 32'h7);
        wctl(8'h00);
        @(negedge clk);
        chk("osc off", 32'({osc_run, dir_eff}), 32'(dir));
        $display("test registers done");
        for (int k = 0; k < 4; k++) begin
            wctl(8'h03 | 8'(k << 4));
            wcnt(16'($urandom));
            pulse(5, 0);
            rcnt("divided");
            wcnt(16'($urandom));
            pulse((1 << k) - 1, 0);
            rcnt("presc cleared");
        end
        wctl(8'h0b);
        repeat (20) @(posedge clk); // start-up wait
        wcnt(16'($urandom));
        pulse(4, 1);
        pulse(4, 0);
        rcnt("osc pin");
        wctl(8'h03);
        wcnt(16'hfffe);
        pulse(1, 0);
        rchk(A_FL, 32'h0, "no early flag");
        pulse(2, 0);
        rcnt("wrap");
        repeat (20) @(posedge clk);
        rchk(A_FL, 32'h1, "sticky flag");
        @(negedge clk);
        chk("irq masked", 32'(irq), 32'h0);
        wr(A_EN, 32'h1, 4'h1, 0);
        men = 1;
        @(negedge clk);
        chk("irq on", 32'(irq), 32'h1);
        wr(A_FL, 32'h0, 4'h1, 0);
        mflag = 0;
        @(negedge clk);
        chk("irq off", 32'(irq), 32'h0);
        $display("test counter done");
        for (int j = 0; j < 3; j++) begin
            // count written while stopped or idle
            wcnt(16'($urandom) | 16'h1);
            wctl(j < 2 ? 8'h03 : 8'h07);
            @(posedge clk);
            trig_a <= (j != 1);
            trig_b <= (j == 1);
            @(posedge clk);
            trig_a <= 1'b0;
            trig_b <= 1'b0;
            if (j < 2) mcnt = 0;
            rcnt("trigger");
            chk("timebase", 32'(tb_ok), 32'(j < 2));
        end
        rchk(A_FL, 32'h0, "trigger flag");
        wctl(8'h03);
        t = $urandom;
        wr(A_LO, 32'(t[7:0]), 4'h1, 1);
        mcnt = t & 8'hff;
        rcnt("write wins");
        $display("test trigger done");
        wctl(8'h13);
        wcnt(16'($urandom));
        sleep <= 1'b1;
        pulse(3, 0);
        rcnt("sleep hold");
        sleep <= 1'b0;
        pulse(1, 0);
        rcnt("presc ran");
        wcnt(16'hffff);
        wctl(8'h07);
        sleep <= 1'b1;
        pulse(3, 0);
        rcnt("async sleep");
        @(negedge clk);
        chk("wake", 32'(irq), 32'(mflag & men));
        @(posedge clk);
        sleep <= 1'b0;
        $display("test sleep done");
        for (int j = 0; j < 2; j++) begin
            wctl(8'h04);
            wcnt(16'h0);
            wctl(8'h01 | 8'(j << 2));
            repeat (400) @(posedge clk);
            wctl(8'h04);
            rgot();
            // 404 core cycles at one tick per four
            chk("tick rate", 32'(cseen > 98 && cseen < 104), 32'h1);
            mcnt = cseen;
            repeat (40) @(posedge clk);
            rcnt("stopped");
        end
        $display("test timer done");
        wctl(8'h13);
        @(posedge clk);
        orst <= 1'b1;
        @(posedge clk);
        orst <= 1'b0;
        rchk(A_EN, 32'h0, "other rst en");
        rchk(A_CT, 32'h13, "other rst ctl");
        rcnt("other rst cnt");
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rchk(A_CT, 32'h0, "por ctl");
        rcnt("por cnt");
        $display("test resets done");
        final_report();
    end
endmodule

`default_nettype wire
